// ==== inc/iom_pkg.sv ====
// Constants, types and decode helpers for the increment/OR/move executor.
// Assumes a single clock domain; all figures are shared by the core files.
package iom_pkg;

    // Instruction field positions
    localparam int unsigned OPC6_HI   = 15;
    localparam int unsigned OPC6_LO   = 10;
    localparam int unsigned D_BIT     = 9;
    localparam int unsigned A_BIT     = 8;
    localparam int unsigned FSEL_HI   = 5;
    localparam int unsigned FSEL_LO   = 4;
    localparam int unsigned KHI_HI    = 3;

    // Opcode patterns
    localparam logic [5:0] OPC6_INC_FILE    = 6'h0A;
    localparam logic [5:0] OPC6_INC_SKIP_Z  = 6'h0F;
    localparam logic [5:0] OPC6_INC_SKIP_NZ = 6'h12;
    localparam logic [5:0] OPC6_OR_FILE     = 6'h04;
    localparam logic [5:0] OPC6_COPY_FILE   = 6'h14;
    localparam logic [7:0] OPC8_IORL   = 8'h09;
    localparam logic [7:0] OPC8_LPTR   = 8'hEE;
    localparam logic [1:0] LPTR_PAD    = 2'h0;
    localparam logic [3:0] TWO_WORD_A  = 4'hC;
    localparam logic [3:0] TWO_WORD_B  = 4'hE;
    localparam logic [1:0] TWO_WORD_BS = 2'h3;

    // Status bit positions
    localparam int unsigned FLG_C  = 0;
    localparam int unsigned FLG_DC = 1;
    localparam int unsigned FLG_Z  = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_N  = 4;
    localparam int unsigned STATUS_W = 5;

    // Instruction cycle phases
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    // Register port map
    localparam logic [3:0] RA_BANK     = 4'h0;
    localparam logic [3:0] RA_ACC      = 4'h1;
    localparam logic [3:0] RA_STATUS   = 4'h2;
    localparam logic [3:0] RA_PTR_BASE = 4'h3;

    localparam logic [7:0]          BANK_RST   = 8'h00;
    localparam logic [7:0]          ACC_RST    = 8'h00;
    localparam logic [STATUS_W-1:0] STATUS_RST = 5'h00;
    localparam logic [3:0]          ACCESS_BANK = 4'h0;
    localparam int unsigned         NUM_PTR    = 3;

    typedef enum logic [1:0] {ST_RUN, ST_PTR_LOW, ST_SKIP1, ST_SKIP2} iom_state_t;
    typedef enum logic [1:0] {ALU_INC, ALU_OR, ALU_PASS} iom_alu_op_t;

    // First word of any two-word instruction
    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:12] == TWO_WORD_A) ||
                      (w[15:12] == TWO_WORD_B && w[11:10] == TWO_WORD_BS);
    endfunction : is_two_word

endpackage : iom_pkg

// ==== src/iom_phase.sv ====
// Four-phase instruction cycle sequencer.
// Assumes an active-low reset whose release is already synchronised.
`timescale 1ns/100ps
module iom_phase
    import iom_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    output logic [1:0]      phase
);
    logic [1:0] phase_reg;
    logic [1:0] phase_next;

    always_comb begin
        phase_next = 2'(phase_reg + 2'h1);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= PH_Q1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;
endmodule : iom_phase

// ==== src/iom_alu.sv ====
// Combinational arithmetic for increment, OR and pass-through.
// Assumes operands are stable for the whole Q4 phase.
`timescale 1ns/100ps
module iom_alu
    import iom_pkg::*;
(
    input  iom_alu_op_t       op,
    input  wire logic [7:0]   a,
    input  wire logic [7:0]   b,
    output logic [7:0]        result,
    output logic [STATUS_W-1:0] flags
);
    logic [8:0] sum;

    always_comb begin
        sum   = {1'b0, a} + 9'h001;
        flags = '0;
        unique case (op)
            ALU_INC:  result = sum[7:0];
            ALU_OR:   result = a | b;
            ALU_PASS: result = a;
            default:  result = a;
        endcase
        flags[FLG_C]  = sum[8];
        flags[FLG_DC] = (a[3:0] == 4'hF);
        flags[FLG_OV] = (a == 8'h7F);
        flags[FLG_N]  = result[7];
        flags[FLG_Z]  = (result == 8'h00);
    end
endmodule : iom_alu

// ==== src/iom_core.sv ====
// Executes increment, skip-increment, OR, move and pointer-load instructions.
// Assumes the fetch path holds INSTR_WORD through Q1 and data memory answers
// a read in the cycle after DMEM_RD.
// How it works
// - Plain increment adds one to the file register and updates C, DC, N, OV and Z.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file.
// - Bank bit 0 addresses the fixed common bank, 1 the bank select register's bank.
// - The 8-bit file field picks any byte inside the chosen 256-byte bank.
// - Increment-skip-zero writes without flags and skips the next word on a zero result.
// - Increment-skip-nonzero writes without flags and skips the next word on nonzero.
// - Skips take one cycle, two on a skip, three when skipping a two-word instruction.
// - OR-literal ORs the accumulator with the literal into the accumulator, N and Z only.
// - OR-with-file ORs accumulator and file to the chosen destination, N and Z only.
// - Load-pointer puts a 12-bit literal into one of three pointers, flags untouched.
// - Load-pointer takes two cycles: high byte in the first, low byte in the second.
// - Move-file copies the file register to the destination in one cycle, N and Z only.
`timescale 1ns/100ps
module iom_core
    import iom_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic [15:0] INSTR_WORD,
    output logic             FETCH_NEXT,
    output logic [11:0]      DMEM_ADDR,
    output logic             DMEM_RD,
    input  wire logic [7:0]  DMEM_RDATA,
    output logic [7:0]       DMEM_WDATA,
    output logic             DMEM_WR,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [7:0]       REG_RDATA
);
    logic [1:0]          rst_sync_reg;
    logic                rst_n;
    logic [1:0]          phase;
    logic                q2;
    logic                q3;
    logic                q4;

    iom_state_t          state_reg,  state_next;
    logic [15:0]         instr_reg,  instr_next;
    logic [7:0]          acc_reg,    acc_next;
    logic [STATUS_W-1:0] status_reg, status_next;
    logic [7:0]          bank_reg,   bank_next;
    logic [1:0]          psel_reg,   psel_next;
    logic [7:0]          ptr_hi_reg [NUM_PTR];
    logic [7:0]          ptr_hi_next[NUM_PTR];
    logic [7:0]          ptr_lo_reg [NUM_PTR];
    logic [7:0]          ptr_lo_next[NUM_PTR];
    logic [11:0]         addr_reg,   addr_next;
    logic                rd_reg,     rd_next;
    logic                wr_reg,     wr_next;
    logic [7:0]          wdata_reg,  wdata_next;
    logic                fetch_reg,  fetch_next;
    logic [7:0]          rdata_reg,  rdata_next;

    logic                run;
    logic [5:0]          opc6;
    logic                op_inc, op_isz, op_isnz, op_orf, op_copy;
    logic                op_iorl, op_lptr, file_op, nz_only;
    iom_alu_op_t         alu_op;
    logic [7:0]          alu_a;
    logic [7:0]          alu_res;
    logic [STATUS_W-1:0] alu_flags;
    logic                skip_taken;

    // Reset release synchroniser; the assertion edge stays asynchronous
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    iom_phase u_phase (
        .clk   (SYS_CLK),
        .rst_n (rst_n),
        .phase (phase)
    );

    assign q2 = (phase == PH_Q2);
    assign q3 = (phase == PH_Q3);
    assign q4 = (phase == PH_Q4);

    // Decode is only live in a normal execute cycle; skipped words do nothing
    assign run      = (state_reg == ST_RUN);
    assign opc6     = instr_reg[OPC6_HI:OPC6_LO];
    assign op_inc   = run && opc6 == OPC6_INC_FILE;
    assign op_isz   = run && opc6 == OPC6_INC_SKIP_Z;
    assign op_isnz  = run && opc6 == OPC6_INC_SKIP_NZ;
    assign op_orf   = run && opc6 == OPC6_OR_FILE;
    assign op_copy  = run && opc6 == OPC6_COPY_FILE;
    assign op_iorl  = run && instr_reg[15:8] == OPC8_IORL;
    assign op_lptr  = run && instr_reg[15:8] == OPC8_LPTR
                      && instr_reg[7:6] == LPTR_PAD;
    assign file_op  = op_inc || op_isz || op_isnz || op_orf || op_copy;
    assign nz_only  = op_orf || op_copy || op_iorl;

    always_comb begin
        if (op_orf || op_iorl) begin
            alu_op = ALU_OR;
        end else if (op_copy) begin
            alu_op = ALU_PASS;
        end else begin
            alu_op = ALU_INC;
        end
        alu_a = file_op ? DMEM_RDATA : instr_reg[7:0];
    end

    iom_alu u_alu (
        .op     (alu_op),
        .a      (alu_a),
        .b      (acc_reg),
        .result (alu_res),
        .flags  (alu_flags)
    );

    assign skip_taken = (op_isz && alu_res == 8'h00)
                     || (op_isnz && alu_res != 8'h00);

    always_comb begin
        state_next  = state_reg;
        instr_next  = instr_reg;
        acc_next    = acc_reg;
        status_next = status_reg;
        bank_next   = bank_reg;
        psel_next   = psel_reg;
        ptr_hi_next = ptr_hi_reg;
        ptr_lo_next = ptr_lo_reg;
        addr_next   = addr_reg;
        rd_next     = 1'b0;
        wr_next     = 1'b0;
        wdata_next  = wdata_reg;
        fetch_next  = q3;
        rdata_next  = 8'h00;

        if (phase == PH_Q1) begin
            instr_next = INSTR_WORD;
        end

        // Software writes first so a core commit in the same cycle wins
        if (REG_WR) begin
            unique case (REG_ADDR)
                RA_BANK:   bank_next   = REG_WDATA;
                RA_ACC:    acc_next    = REG_WDATA;
                RA_STATUS: status_next = REG_WDATA[STATUS_W-1:0];
                default:   ;
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                RA_BANK:   rdata_next = bank_reg;
                RA_ACC:    rdata_next = acc_reg;
                RA_STATUS: rdata_next = {{(8-STATUS_W){1'b0}}, status_reg};
                default:   rdata_next = 8'h00;
            endcase
            for (int i = 0; i < NUM_PTR; i++) begin
                if (REG_ADDR == 4'(RA_PTR_BASE + 2 * i)) begin
                    rdata_next = ptr_hi_reg[i];
                end
                if (REG_ADDR == 4'(RA_PTR_BASE + 2 * i + 1)) begin
                    rdata_next = ptr_lo_reg[i];
                end
            end
        end

        // Read issued at end of Q2 so data arrives during Q4
        if (q2 && file_op) begin
            rd_next = 1'b1;
            if (instr_reg[A_BIT]) begin
                addr_next = {bank_reg[3:0], instr_reg[7:0]};
            end else begin
                addr_next = {ACCESS_BANK, instr_reg[7:0]};
            end
        end

        if (q4) begin
            unique case (state_reg)
                ST_RUN: begin
                    if (file_op || op_iorl) begin
                        wdata_next = alu_res;
                        if (file_op && instr_reg[D_BIT]) begin
                            wr_next = 1'b1;
                        end else begin
                            acc_next = alu_res;
                        end
                    end
                    if (op_inc) begin
                        status_next = alu_flags;
                    end
                    if (nz_only) begin
                        status_next[FLG_N] = alu_flags[FLG_N];
                        status_next[FLG_Z] = alu_flags[FLG_Z];
                    end
                    if (op_lptr) begin
                        psel_next = instr_reg[FSEL_HI:FSEL_LO];
                        if (32'(instr_reg[FSEL_HI:FSEL_LO]) < NUM_PTR) begin
                            ptr_hi_next[instr_reg[FSEL_HI:FSEL_LO]] =
                                {4'h0, instr_reg[KHI_HI:0]};
                        end
                        state_next = ST_PTR_LOW;
                    end else if (skip_taken) begin
                        state_next = ST_SKIP1;
                    end
                end
                ST_PTR_LOW: begin
                    if (32'(psel_reg) < NUM_PTR) begin
                        ptr_lo_next[psel_reg] = instr_reg[7:0];
                    end
                    state_next = ST_RUN;
                end
                ST_SKIP1: begin
                    // Discarded word stays a no-op; its second word too
                    if (is_two_word(instr_reg)) begin
                        state_next = ST_SKIP2;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
                ST_SKIP2: state_next = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_RUN;
            instr_reg  <= 16'h0000;
            acc_reg    <= ACC_RST;
            status_reg <= STATUS_RST;
            bank_reg   <= BANK_RST;
            psel_reg   <= 2'h0;
            for (int i = 0; i < NUM_PTR; i++) begin
                ptr_hi_reg[i] <= 8'h00;
                ptr_lo_reg[i] <= 8'h00;
            end
            addr_reg   <= 12'h000;
            rd_reg     <= 1'b0;
            wr_reg     <= 1'b0;
            wdata_reg  <= 8'h00;
            fetch_reg  <= 1'b0;
            rdata_reg  <= 8'h00;
        end else begin
            state_reg  <= state_next;
            instr_reg  <= instr_next;
            acc_reg    <= acc_next;
            status_reg <= status_next;
            bank_reg   <= bank_next;
            psel_reg   <= psel_next;
            ptr_hi_reg <= ptr_hi_next;
            ptr_lo_reg <= ptr_lo_next;
            addr_reg   <= addr_next;
            rd_reg     <= rd_next;
            wr_reg     <= wr_next;
            wdata_reg  <= wdata_next;
            fetch_reg  <= fetch_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign FETCH_NEXT = fetch_reg;
    assign DMEM_ADDR  = addr_reg;
    assign DMEM_RD    = rd_reg;
    assign DMEM_WDATA = wdata_reg;
    assign DMEM_WR    = wr_reg;
    assign REG_RDATA  = rdata_reg;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    property p_inc_flags;
        q4 && op_inc |=> status_reg[FLG_C] == ($past(DMEM_RDATA) == 8'hFF)
            && status_reg[FLG_OV] == ($past(DMEM_RDATA) == 8'h7F);
    endproperty
    a_inc_flags: assert property (p_inc_flags) else $error("increment flags wrong");

    property p_dest_file;
        q4 && file_op && instr_reg[D_BIT] |=> DMEM_WR && DMEM_WDATA == $past(alu_res)
            && acc_reg == $past(acc_reg);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination missed");

    property p_dest_acc;
        q4 && file_op && !instr_reg[D_BIT] && !REG_WR |=> !DMEM_WR
            && acc_reg == $past(alu_res);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination missed");

    property p_bank_sel;
        q2 && file_op |=> DMEM_RD && DMEM_ADDR[7:0] == $past(instr_reg[7:0])
            && DMEM_ADDR[11:8] == ($past(instr_reg[A_BIT]) ? $past(bank_reg[3:0])
                                                          : ACCESS_BANK);
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank address wrong");

    property p_skip_flags;
        q4 && (op_isz || op_isnz) && !REG_WR |=> status_reg == $past(status_reg);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip op changed flags");

    property p_skip_taken;
        q4 && ((op_isz && alu_res == 8'h00) || (op_isnz && alu_res != 8'h00))
            |=> state_reg == ST_SKIP1 [*4];
    endproperty
    a_skip_taken: assert property (p_skip_taken) else $error("skip not taken");

    property p_skip_two;
        q4 && state_reg == ST_SKIP1 && is_two_word(instr_reg)
            |=> state_reg == ST_SKIP2 [*4] ##1 state_reg == ST_RUN;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("two-word skip length wrong");

    property p_skip_quiet;
        state_reg != ST_RUN |-> !rd_next && !wr_next;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("memory access in no-op cycle");

    property p_or_literal;
        q4 && op_iorl |=> acc_reg == ($past(acc_reg) | $past(instr_reg[7:0]))
            && status_reg[FLG_C] == $past(status_reg[FLG_C]);
    endproperty
    a_or_literal: assert property (p_or_literal) else $error("literal OR wrong");

    property p_ptr_load;
        q4 && op_lptr && instr_reg[FSEL_HI:FSEL_LO] != 2'h3
            |=> state_reg == ST_PTR_LOW [*4] ##1 state_reg == ST_RUN
                && ptr_lo_reg[psel_reg] == $past(instr_reg[7:0], 2)
                && ptr_hi_reg[psel_reg] == {4'h0, $past(instr_reg[KHI_HI:0], 5)};
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");

    property p_nz_flags;
        q4 && nz_only |=> status_reg[FLG_N] == $past(alu_res[7])
            && status_reg[FLG_Z] == ($past(alu_res) == 8'h00);
    endproperty
    a_nz_flags: assert property (p_nz_flags) else $error("N or Z flag wrong");

    c_skip_zero: cover property (q4 && op_isz && alu_res == 8'h00);
    c_skip_two:  cover property (q4 && state_reg == ST_SKIP1 && is_two_word(instr_reg));
    c_ptr_load:  cover property (q4 && state_reg == ST_PTR_LOW);
    c_copy_acc:  cover property (q4 && op_copy && !instr_reg[D_BIT]);
endmodule : iom_core

// ==== sim/iom_mem_model.sv ====
// Program store and banked data memory facing the executor core.
// Assumes fetch advances on FETCH_NEXT and reads answer one cycle after DMEM_RD.
`timescale 1ns/100ps
module iom_mem_model
    import iom_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        FETCH_NEXT,
    output logic [15:0]      INSTR_WORD,
    input  wire logic [11:0] DMEM_ADDR,
    input  wire logic        DMEM_RD,
    output logic [7:0]       DMEM_RDATA,
    input  wire logic [7:0]  DMEM_WDATA,
    input  wire logic        DMEM_WR
);
    logic [15:0] prog [0:63];
    logic [7:0]  dmem [0:4095];
    logic [5:0]  pc_reg = 6'h00;
    logic [7:0]  rd_reg = 8'h5A;

    // Skipped and second words are fetched like any other word
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_reg <= 6'h00;
        end else if (FETCH_NEXT) begin
            pc_reg <= pc_reg + 6'h01;
        end
    end

    // Outside the answer cycle the data lines toggle so stale data never passes
    always @(posedge SYS_CLK) begin
        rd_reg <= DMEM_RD ? dmem[DMEM_ADDR] : ~rd_reg;
        if (DMEM_WR) begin
            dmem[DMEM_ADDR] <= DMEM_WDATA;
        end
    end

    assign INSTR_WORD = prog[pc_reg];
    assign DMEM_RDATA = rd_reg;
endmodule : iom_mem_model

// ==== sim/increment_or_move_exec_test.sv ====
// Self-checking bench for the executor core with its memory model.
// Assumes the register map and four-clock instruction cycle of the core.
`timescale 1ns/100ps
module increment_or_move_exec_test;
    import iom_pkg::*;
    logic        SYS_CLK   = 1'b0;
    logic        ARST_N    = 1'b0;
    logic [3:0]  REG_ADDR  = 4'h0;
    logic [7:0]  REG_WDATA = 8'h00;
    logic        REG_WR    = 1'b0;
    logic        REG_RD    = 1'b0;
    logic [15:0] INSTR_WORD;
    logic        FETCH_NEXT;
    logic [11:0] DMEM_ADDR;
    logic        DMEM_RD;
    logic [7:0]  DMEM_RDATA;
    logic [7:0]  DMEM_WDATA;
    logic        DMEM_WR;
    logic [7:0]  REG_RDATA;
    int          n_errors = 0;
    int          n_tests  = 0;
    int          cyc      = 0;
    int          pi       = 4;
    int          rd_log [$];

    iom_core uut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .INSTR_WORD(INSTR_WORD),
        .FETCH_NEXT(FETCH_NEXT), .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD),
        .DMEM_RDATA(DMEM_RDATA), .DMEM_WDATA(DMEM_WDATA), .DMEM_WR(DMEM_WR),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA));
    iom_mem_model mem (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .FETCH_NEXT(FETCH_NEXT),
        .INSTR_WORD(INSTR_WORD), .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD),
        .DMEM_RDATA(DMEM_RDATA), .DMEM_WDATA(DMEM_WDATA), .DMEM_WR(DMEM_WR));

    initial begin
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    // Read pulses are logged so cycle counts show as spacing between file ops
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (DMEM_RD === 1'b1) begin
            rd_log.push_back(cyc);
        end
        if (cyc == 3000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test;
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR    <= 1'b0;
    endtask : reg_wr

    task automatic expect_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge SYS_CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD   <= 1'b0;
        #1;
        check(REG_RDATA, e);
    endtask : expect_reg

    function automatic logic [15:0] fop(input logic [5:0] o, input logic d, input logic a,
                                        input logic [7:0] f);
        return {o, d, a, f};
    endfunction : fop

    task automatic put(input logic [15:0] w);
        mem.prog[pi] = w;
        pi++;
    endtask : put

    task automatic lf(input logic [1:0] s, input logic [11:0] k);
        put({OPC8_LPTR, LPTR_PAD, s, k[11:8]});
        put({8'hF0, k[7:0]});
    endtask : lf

    // Unknown words run as no-ops, so the first four slots give setup time
    task automatic clear;
        int i;
        pi = 4;
        for (i = 0; i < 64; i++) mem.prog[i] = 16'hFFFF;
        for (i = 0; i < 4096; i++) mem.dmem[i] = 8'h00;
    endtask : clear

    task automatic start(input logic [7:0] bank, input logic [7:0] acc, input logic [4:0] st);
        ARST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        rd_log.delete();
        reg_wr(RA_BANK, bank);
        reg_wr(RA_ACC, acc);
        reg_wr(RA_STATUS, {3'h0, st});
        repeat (100) @(posedge SYS_CLK);
    endtask : start

    task automatic test_inc;
        clear();
        mem.dmem[12'h580] = 8'hFF;
        mem.dmem[12'h080] = 8'h33;
        mem.dmem[12'h081] = 8'h7F;
        put(fop(OPC6_INC_FILE, 1'b1, 1'b1, 8'h80));
        put(fop(OPC6_INC_FILE, 1'b0, 1'b0, 8'h81));
        start(8'h05, 8'h00, 5'h00);
        check(mem.dmem[12'h580], 8'h00);
        check(mem.dmem[12'h080], 8'h33);
        check(mem.dmem[12'h081], 8'h7F);
        expect_reg(RA_ACC, 8'h80);
        expect_reg(RA_STATUS, 8'h1A);
    endtask : test_inc

    task automatic test_skip;
        clear();
        mem.dmem[12'h010] = 8'hFF;
        mem.dmem[12'h012] = 8'h80;
        put(fop(OPC6_INC_SKIP_Z, 1'b0, 1'b0, 8'h10));
        put({OPC8_IORL, 8'h55});
        put(fop(OPC6_INC_SKIP_NZ, 1'b1, 1'b0, 8'h11));
        lf(2'h1, 12'h123);
        put(fop(OPC6_COPY_FILE, 1'b1, 1'b0, 8'h12));
        start(8'h00, 8'h44, 5'h0A);
        expect_reg(RA_ACC, 8'h00);
        check(mem.dmem[12'h011], 8'h01);
        expect_reg(4'h5, 8'h00);
        expect_reg(RA_STATUS, 8'h1A);
        check(8'(rd_log[1] - rd_log[0]), 8'd8);
        check(8'(rd_log[2] - rd_log[1]), 8'd12);
    endtask : test_skip

    task automatic test_or_move;
        clear();
        mem.dmem[12'h020] = 8'h05;
        mem.dmem[12'h330] = 8'h40;
        mem.dmem[12'h031] = 8'h40;
        put(fop(OPC6_INC_SKIP_Z, 1'b1, 1'b0, 8'h20));
        put({OPC8_IORL, 8'h35});
        put(fop(OPC6_OR_FILE, 1'b1, 1'b1, 8'h30));
        put(fop(OPC6_OR_FILE, 1'b0, 1'b0, 8'h31));
        put(fop(OPC6_COPY_FILE, 1'b1, 1'b0, 8'h32));
        start(8'h03, 8'h9A, 5'h0B);
        check(mem.dmem[12'h020], 8'h06);
        check(8'(rd_log[1] - rd_log[0]), 8'd8);
        check(mem.dmem[12'h330], 8'hFF);
        expect_reg(RA_ACC, 8'hFF);
        expect_reg(RA_STATUS, 8'h0F);
    endtask : test_or_move

    task automatic test_ptr;
        logic [7:0] exp_p [6];
        int         i;
        exp_p = '{8'h03, 8'hAB, 8'h01, 8'h23, 8'h0C, 8'h5E};
        clear();
        mem.dmem[12'h000] = 8'h01;
        mem.dmem[12'h001] = 8'h02;
        put(fop(OPC6_COPY_FILE, 1'b0, 1'b0, 8'h00));
        lf(2'h0, 12'h3AB);
        lf(2'h1, 12'h123);
        lf(2'h2, 12'hC5E);
        put(fop(OPC6_COPY_FILE, 1'b0, 1'b0, 8'h01));
        start(8'h00, 8'h00, 5'h0B);
        for (i = 0; i < 6; i++) begin
            expect_reg(RA_PTR_BASE + 4'(i), exp_p[i]);
        end
        check(8'(rd_log[1] - rd_log[0]), 8'd28);
        reg_wr(RA_PTR_BASE, 8'h77);
        expect_reg(RA_PTR_BASE, 8'h03);
        expect_reg(4'hF, 8'h00);
        expect_reg(RA_ACC, 8'h02);
        expect_reg(RA_STATUS, 8'h0B);
    endtask : test_ptr

    initial begin
        clear();
        repeat (10) @(posedge SYS_CLK);
        test_inc();
        test_skip();
        test_or_move();
        test_ptr();
        finish_test();
    end
endmodule : increment_or_move_exec_test
